// ==== tss_defs.vh ====
// Shared constants of the trigger state sequencer
`ifndef TSS_DEFS_VH
`define TSS_DEFS_VH

// Build options
`define TSS_GRP_W          64
`define TSS_NSTATES        5
`define TSS_STATE_W        3
`define TSS_RAM_ADDR_BITS  9
`define TSS_TAG_W          10
`define TSS_EXT_W          8
`define TSS_CNT_W          32
`define TSS_ACT_W          8

// Register bus
`define TSS_ADDR_W         12
`define TSS_DATA_W         32

// Register byte offsets
`define TSS_OFF_CTRL       12'h000
`define TSS_OFF_PTACT      12'h010
`define TSS_OFF_CURSTATE   12'h020
`define TSS_OFF_CURCNT     12'h024
`define TSS_OFF_CURACT     12'h028
`define TSS_OFF_TAG        12'h02C
`define TSS_OFF_CFGID      12'h0C8
`define TSS_OFF_CFGID2     12'h0C4
// Per-state block: base + state * stride + field * 4
`define TSS_OFF_STBASE     12'h100
`define TSS_ST_STRIDE_SH   6
`define TSS_FLD_NEXT       4'h0
`define TSS_FLD_CTRL       4'h1
`define TSS_FLD_ACT        4'h2
`define TSS_FLD_ALTNEXT    4'h3
`define TSS_FLD_ALTACT     4'h4
`define TSS_FLD_CNTTGT     4'h5
`define TSS_FLD_EXTMASK    4'h6
`define TSS_FLD_EXTCMP     4'h7
`define TSS_FLD_MASKLO     4'h8
`define TSS_FLD_MASKHI     4'h9
`define TSS_FLD_CMPLO      4'hA
`define TSS_FLD_CMPHI      4'hB

// State control fields
`define TSS_SC_KIND        0
`define TSS_SC_ALTKIND     1
`define TSS_SC_SRC         2
`define TSS_SC_BRK         3
`define TSS_SC_CLR         4
`define TSS_SC_TRACE       5
`define TSS_SC_CAPTAG      6
`define TSS_SC_USETAG      7
`define TSS_SC_W           8

// Action byte fields
`define TSS_ACT_CTO_LO     0
`define TSS_ACT_HALT       2
`define TSS_ACT_TRACE      3
`define TSS_ACT_GEN_LO     4

// Identification fields, run bit and state codes
`define TSS_ID_COND_LO     16
`define TSS_ID_TAG_LO      20
`define TSS_ID_COND_VAL    4'h1
`define TSS_CTRL_RUN       0
`define TSS_FINAL_STATE    3'h7
`define TSS_RESET_STATE    3'h0
`endif

// ==== tss_sequencer.v ====
// Trigger state sequencer with register port and debug permission gating
// Function
// RULE1: Signal condition needs masked probe and masked external inputs both matching.
// RULE2: Fully masked half with zero compare value is always true.
// RULE3: Counter condition fires when per-state counter reaches its target.
// RULE4: Each condition comes from signal compare or counter compare, never both.
// RULE5: Next state may point back to an earlier state, forming loops.
// RULE6: Loop counter active when loop-break is 1 and auto-clear is 0.
// RULE7: Loop counter ends the loop, stops trace and limits output toggles.
// RULE8: Conditional option adds alternative condition; config field [19:16] reads 1.
// RULE9: Primary match wins, else alternative match, else nothing changes.
// RULE10: When both match, primary output and next state are taken.
// RULE11: With loop-break, no match follows the primary branch.
// RULE12: Loop-break alternative counter: increments go alternative, final match ends.
// RULE13: Alternative cycle count fires at target with kind 1 and source 0.
// RULE14: Primary counter match beats same-cycle alternative signal match.
// RULE15: Trace enable per state, independent of which comparison fired.
// RULE16: Address-request signal match latches tag from low probe bits.
// RULE17: Tag capture needs both options; config field [24:20] shows width.
// RULE18: Secure builds run only while secure non-invasive debug is allowed.
// RULE19: Clock halt request asserts only while invasive debug is allowed.
// RULE20: Withdrawn non-invasive permission clears run enable to zero.
// RULE21: Non-secure builds gate on non-secure non-invasive permission instead.
// RULE22: Probe 64 or 128 bits, trace memory 2^9 deep, 4 or 5 states.
// RULE23: After run enable, before first match, pre-trigger setting drives outputs.
// RULE24: Per-state counter clears whenever a different state is entered.
//
// The implementer's own choices: the register offsets and strobed register access.
`include "tss_defs.vh"

module tss_sequencer #(
    parameter SECURE_VIS       = 1,
    parameter COND_OPT         = 1,
    parameter TAG_OPT          = 1,
    parameter [4:0] TAG_WIDTH  = 5'd10
) (
    input  wire                      core_clk,
    input  wire                      srst,
    input  wire [`TSS_ADDR_W-1:0]    reg_addr,
    input  wire [`TSS_DATA_W-1:0]    reg_wdata,
    input  wire                      reg_wr,
    input  wire                      reg_rd,
    output reg  [`TSS_DATA_W-1:0]    reg_rdata,
    input  wire [`TSS_GRP_W-1:0]     probe_signal_group,
    input  wire [`TSS_EXT_W-1:0]     ext_trigger_in,
    input  wire                      addr_request,
    input  wire                      invasive_debug_allow,
    input  wire                      noninvasive_debug_allow,
    input  wire                      secure_invasive_debug_allow,
    input  wire                      secure_noninvasive_debug_allow,
    output reg  [3:0]                general_outputs,
    output reg  [1:0]                cross_trigger_outputs,
    output reg                       clock_halt_request,
    output reg                       trace_enable,
    output reg  [`TSS_STATE_W-1:0]   trace_state
);

    localparam NS  = `TSS_NSTATES;                  // see RULE22
    localparam SW  = `TSS_STATE_W;
    localparam GW  = `TSS_GRP_W;
    localparam CW  = `TSS_CNT_W;
    localparam AW  = `TSS_ACT_W;
    localparam TGW = `TSS_TAG_W;
    localparam TAG_ON = (TAG_OPT != 0) && (COND_OPT != 0);

    // Per-state configuration held as arrays
    reg [SW-1:0]         nxt_r      [0:NS-1];
    reg [SW-1:0]         alt_nxt_r  [0:NS-1];
    reg [`TSS_SC_W-1:0]  sc_r       [0:NS-1];
    reg [AW-1:0]         act_r      [0:NS-1];
    reg [AW-1:0]         alt_act_r  [0:NS-1];
    reg [CW-1:0]         tgt_r      [0:NS-1];
    reg [`TSS_EXT_W-1:0] emask_r    [0:NS-1];
    reg [`TSS_EXT_W-1:0] ecmp_r     [0:NS-1];
    reg [GW-1:0]         smask_r    [0:NS-1];
    reg [GW-1:0]         scmp_r     [0:NS-1];

    reg                  run_r;
    reg                  run_d_r;
    reg  [AW-1:0]        ptact_r;
    reg  [AW-1:0]        cur_act_r;
    reg  [SW-1:0]        state_r;
    reg  [CW-1:0]        cnt_r;
    reg  [TGW-1:0]       tag_r;
    reg                  trig_seen_r;

    // Decode of a per-state register address
    function [SW-1:0] st_of;
        input [`TSS_ADDR_W-1:0] a;
        begin
            st_of = a[`TSS_ST_STRIDE_SH+SW-1:`TSS_ST_STRIDE_SH];
        end
    endfunction

    function [3:0] fld_of;
        input [`TSS_ADDR_W-1:0] a;
        begin
            fld_of = a[5:2];
        end
    endfunction

    function is_st;
        input [`TSS_ADDR_W-1:0] a;
        begin
            is_st = (a >= `TSS_OFF_STBASE) && (st_of(a - `TSS_OFF_STBASE) < NS)
                    && (a[1:0] == 2'b00);
        end
    endfunction

    wire [`TSS_ADDR_W-1:0] st_off = reg_addr - `TSS_OFF_STBASE;
    wire [SW-1:0]          wst    = st_of(st_off);
    wire [3:0]             wfld   = fld_of(st_off);

    // Permission gating
    wire nid_ok = (SECURE_VIS != 0) ? secure_noninvasive_debug_allow  // see RULE18
                                    : noninvasive_debug_allow;       // see RULE21
    wire inv_ok = (SECURE_VIS != 0) ? secure_invasive_debug_allow
                                    : invasive_debug_allow;
    wire active = run_r && nid_ok;
    wire run_go = run_r && !run_d_r;
    wire at_end = (state_r == `TSS_FINAL_STATE);

    // Current-state comparisons
    wire [SW-1:0] s = (state_r < NS) ? state_r : `TSS_RESET_STATE;
    wire [`TSS_SC_W-1:0] sc = sc_r[s];
    wire [GW-1:0] tag_ext = {{(GW-TGW){1'b0}}, tag_r};
    wire [GW-1:0] tag_mask = ~({GW{1'b1}} << TAG_WIDTH);
    // Stored tag may replace the compare value in its low bits
    wire [GW-1:0] cmp_val = (TAG_ON && sc[`TSS_SC_USETAG]) ?
                            ((scmp_r[s] & ~tag_mask) | tag_ext) : scmp_r[s];
    wire sig_hit = (((probe_signal_group & smask_r[s]) ==
                     (cmp_val & smask_r[s])) &&
                    ((ext_trigger_in & emask_r[s]) ==
                     (ecmp_r[s] & emask_r[s])));       // see RULE1, RULE2
    wire cnt_hit = (cnt_r == tgt_r[s]);                 // see RULE3
    wire brk     = sc[`TSS_SC_BRK] && !sc[`TSS_SC_CLR]; // see RULE6
    // Counted events: signal matches or cycles
    wire cnt_inc = sc[`TSS_SC_SRC] ? sig_hit : 1'b1;

    // One source per condition
    wire pri_hit = sc[`TSS_SC_KIND] ? cnt_hit : sig_hit;  // see RULE4
    wire alt_sel = (COND_OPT != 0);                       // see RULE8
    wire alt_hit = alt_sel && (sc[`TSS_SC_ALTKIND] ?
                   (cnt_hit && (sc[`TSS_SC_SRC] == 1'b0 || brk)) :
                   sig_hit);                              // see RULE13

    reg [SW-1:0] st_nxt;
    reg [AW-1:0] act_nxt;
    reg          fired;
    always @* begin
        st_nxt  = state_r;
        act_nxt = cur_act_r;
        fired   = 1'b0;
        if (state_r == `TSS_FINAL_STATE) begin
            st_nxt = state_r;
        end else if (pri_hit) begin                       // see RULE10, RULE14
            st_nxt  = nxt_r[s];                           // see RULE5
            act_nxt = act_r[s];
            fired   = 1'b1;
        end else if (alt_sel && brk && sc[`TSS_SC_ALTKIND]) begin
            if (cnt_hit) begin
                st_nxt  = `TSS_FINAL_STATE;               // see RULE12, RULE7
                act_nxt = alt_act_r[s];
                fired   = 1'b1;
            end else if (cnt_inc) begin
                st_nxt = alt_nxt_r[s];
            end else begin
                st_nxt = nxt_r[s];                        // see RULE11
            end
        end else if (alt_hit) begin                       // see RULE9
            st_nxt  = alt_nxt_r[s];
            act_nxt = alt_act_r[s];
            fired   = 1'b1;
        end
    end

    // Register writes, run control and per-state storage
    integer i;
    always @(posedge core_clk) begin
        if (srst) begin
            run_r   <= 1'b0;
            ptact_r <= {AW{1'b0}};
            for (i = 0; i < NS; i = i + 1) begin
                nxt_r[i]     <= {SW{1'b0}};
                alt_nxt_r[i] <= {SW{1'b0}};
                sc_r[i]      <= {`TSS_SC_W{1'b0}};
                act_r[i]     <= {AW{1'b0}};
                alt_act_r[i] <= {AW{1'b0}};
                tgt_r[i]     <= {CW{1'b0}};
                emask_r[i]   <= {`TSS_EXT_W{1'b0}};
                ecmp_r[i]    <= {`TSS_EXT_W{1'b0}};
                smask_r[i]   <= {GW{1'b0}};
                scmp_r[i]    <= {GW{1'b0}};
            end
        end else begin
            if (reg_wr && reg_addr == `TSS_OFF_CTRL)
                run_r <= reg_wdata[`TSS_CTRL_RUN];
            if (run_r && !nid_ok)
                run_r <= 1'b0;                            // see RULE20
            if (reg_wr && reg_addr == `TSS_OFF_PTACT)
                ptact_r <= reg_wdata[AW-1:0];
            if (reg_wr && is_st(reg_addr)) begin
                case (wfld)
                    `TSS_FLD_NEXT:    nxt_r[wst]     <= reg_wdata[SW-1:0];
                    `TSS_FLD_CTRL:    sc_r[wst]      <= reg_wdata[`TSS_SC_W-1:0];
                    `TSS_FLD_ACT:     act_r[wst]     <= reg_wdata[AW-1:0];
                    `TSS_FLD_ALTNEXT: alt_nxt_r[wst] <= reg_wdata[SW-1:0];
                    `TSS_FLD_ALTACT:  alt_act_r[wst] <= reg_wdata[AW-1:0];
                    `TSS_FLD_CNTTGT:  tgt_r[wst]     <= reg_wdata;
                    `TSS_FLD_EXTMASK:
                        emask_r[wst] <= reg_wdata[`TSS_EXT_W-1:0];
                    `TSS_FLD_EXTCMP:
                        ecmp_r[wst] <= reg_wdata[`TSS_EXT_W-1:0];
                    `TSS_FLD_MASKLO:  smask_r[wst][31:0]  <= reg_wdata;
                    `TSS_FLD_MASKHI:  smask_r[wst][63:32] <= reg_wdata;
                    `TSS_FLD_CMPLO:   scmp_r[wst][31:0]   <= reg_wdata;
                    `TSS_FLD_CMPHI:   scmp_r[wst][63:32]  <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    // Sequencer state, counter and tag
    always @(posedge core_clk) begin
        if (srst) begin
            state_r     <= `TSS_RESET_STATE;
            cnt_r       <= {CW{1'b0}};
            cur_act_r   <= {AW{1'b0}};
            tag_r       <= {TGW{1'b0}};
            trig_seen_r <= 1'b0;
            run_d_r     <= 1'b0;
        end else begin
            run_d_r <= run_r;
            if (run_r && !run_d_r) begin
                state_r     <= `TSS_RESET_STATE;
                cnt_r       <= {CW{1'b0}};
                cur_act_r   <= ptact_r;                   // see RULE23
                trig_seen_r <= 1'b0;
            end else if (active && !at_end) begin         // see RULE18
                // Final state freezes counter, action and tag
                state_r   <= st_nxt;
                cur_act_r <= act_nxt;
                if (fired)
                    trig_seen_r <= 1'b1;
                if (st_nxt != state_r)
                    cnt_r <= {CW{1'b0}};                  // see RULE24
                else if (sc[`TSS_SC_CLR] && cnt_hit)
                    cnt_r <= {CW{1'b0}};
                else if (cnt_inc && !cnt_hit)
                    cnt_r <= cnt_r + 1'b1;
                if (TAG_ON && sc[`TSS_SC_CAPTAG] && sig_hit && addr_request)
                    tag_r <= probe_signal_group[TGW-1:0] &
                             tag_mask[TGW-1:0];           // see RULE16, RULE17
            end
        end
    end

    // Run start shows the pre-trigger setting, never a stale action
    wire [AW-1:0] act_out = run_go ? ptact_r : act_nxt;   // see RULE23
    // Action outputs and trace enable driven only while active; trace_state always follows state_r
    always @(posedge core_clk) begin
        if (srst) begin
            general_outputs       <= 4'h0;
            cross_trigger_outputs <= 2'h0;
            clock_halt_request    <= 1'b0;
            trace_enable          <= 1'b0;
            trace_state           <= `TSS_RESET_STATE;
        end else begin
            general_outputs       <= active ? act_out[`TSS_ACT_GEN_LO+3:
                                     `TSS_ACT_GEN_LO] : 4'h0;
            cross_trigger_outputs <= active ? act_out[`TSS_ACT_CTO_LO+1:
                                     `TSS_ACT_CTO_LO] : 2'h0;
            clock_halt_request    <= active && inv_ok &&
                                     act_out[`TSS_ACT_HALT];     // see RULE19
            // After the first match trace follows the per-state flag, not the firing branch
            trace_enable          <= active && (run_go ?
                                     ptact_r[`TSS_ACT_TRACE] :
                                     !at_end && (trig_seen_r ?
                                     sc[`TSS_SC_TRACE] :
                                     cur_act_r[`TSS_ACT_TRACE])); // see RULE15
            trace_state           <= state_r;
        end
    end

    // Read port, data one cycle after the strobe
    wire [`TSS_DATA_W-1:0] id_word =
        {7'h00, (TAG_ON ? TAG_WIDTH : 5'd0), 20'h0_0000};        // see RULE17
    wire [`TSS_DATA_W-1:0] id2_word =
        {12'h000, (COND_OPT != 0) ? `TSS_ID_COND_VAL : 4'h0, 16'h0000};
    always @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `TSS_OFF_CTRL:     reg_rdata <= {31'h0, run_r};
                `TSS_OFF_PTACT:    reg_rdata <= {24'h00_0000, ptact_r};
                `TSS_OFF_CURSTATE: reg_rdata <= {29'h0, state_r};
                `TSS_OFF_CURCNT:   reg_rdata <= cnt_r;
                `TSS_OFF_CURACT:   reg_rdata <= {24'h00_0000, cur_act_r};
                `TSS_OFF_TAG:      reg_rdata <= {{(32-TGW){1'b0}}, tag_r};
                `TSS_OFF_CFGID:    reg_rdata <= id2_word;        // see RULE8
                `TSS_OFF_CFGID2:   reg_rdata <= id_word;
                default:           reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule

// ==== tss_sequencer_monitor.sv ====
// Port-level checker for the trigger state sequencer
`include "tss_defs.vh"
module tss_sequencer_monitor #(
    parameter SECURE_VIS      = 1,
    parameter COND_OPT        = 1,
    parameter TAG_OPT         = 1,
    parameter [4:0] TAG_WIDTH = 5'h0A
) (
    input wire logic                    core_clk,
    input wire logic                    srst,
    input wire logic [`TSS_ADDR_W-1:0]  reg_addr,
    input wire logic [`TSS_DATA_W-1:0]  reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [`TSS_DATA_W-1:0]  reg_rdata,
    input wire logic                    invasive_debug_allow,
    input wire logic                    noninvasive_debug_allow,
    input wire logic                    secure_invasive_debug_allow,
    input wire logic                    secure_noninvasive_debug_allow,
    input wire logic [3:0]              general_outputs,
    input wire logic [1:0]              cross_trigger_outputs,
    input wire logic                    clock_halt_request,
    input wire logic                    trace_enable,
    input wire logic [`TSS_STATE_W-1:0] trace_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       run_ok;
    logic       halt_ok;
    logic [7:0] ptact_r;
    assign run_ok  = SECURE_VIS ? secure_noninvasive_debug_allow
                                : noninvasive_debug_allow;
    assign halt_ok = SECURE_VIS ? secure_invasive_debug_allow
                                : invasive_debug_allow;
    // Shadow copy, the setting itself is not visible at the ports
    always_ff @(posedge core_clk) begin
        if (srst)
            ptact_r <= 8'h00;
        else if (reg_wr && reg_addr == `TSS_OFF_PTACT)
            ptact_r <= reg_wdata[7:0];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_run_go;
        reg_wr && reg_addr == `TSS_OFF_CTRL && reg_wdata[0] && run_ok
        && trace_state == 3'h0 && general_outputs == 4'h0 && !trace_enable;
    endsequence
    // A run write restarts the sequence; its effect lags two cycles
    sequence s_final_kept;
        !reg_wr [*3] ##0 (trace_state == `TSS_FINAL_STATE && run_ok)
        ##1 !reg_wr && run_ok ##1 run_ok;
    endsequence
    chk_pretrig_out: assert property (
        s_run_go ##1 run_ok ##1 (run_ok && trace_state == 3'h0)
        |-> general_outputs == ptact_r[7:4] && trace_enable == ptact_r[3]
            && cross_trigger_outputs == ptact_r[1:0])
        else $error("pre-trigger outputs differ from setting");
    chk_final_holds: assert property (
        s_final_kept |-> trace_state == `TSS_FINAL_STATE)
        else $error("final state left while running");
    chk_gate_silent: assert property (
        !run_ok [*3] |-> general_outputs == 4'h0 && !clock_halt_request
            && cross_trigger_outputs == 2'h0 && !trace_enable)
        else $error("outputs active without permission");
    chk_halt_allow: assert property (
        clock_halt_request |-> halt_ok || $past(halt_ok))
        else $error("halt request without invasive permission");
    chk_cfg_cond: assert property (
        reg_rd && reg_addr == `TSS_OFF_CFGID
        |=> reg_rdata[19:16] == (COND_OPT ? `TSS_ID_COND_VAL : 4'h0))
        else $error("conditional option field wrong");
    chk_cfg_tagw: assert property (
        reg_rd && reg_addr == `TSS_OFF_CFGID2
        |=> reg_rdata[24:20] == ((TAG_OPT && COND_OPT) ? TAG_WIDTH : 5'h00))
        else $error("tag width field wrong");
    chk_rd_quiet: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    chk_unmapped_zero: assert property (
        reg_rd && reg_addr == 12'h0F0 |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");
endmodule

bind tss_sequencer tss_sequencer_monitor #(
    .SECURE_VIS(SECURE_VIS), .COND_OPT(COND_OPT),
    .TAG_OPT(TAG_OPT), .TAG_WIDTH(TAG_WIDTH)
) i_tss_sequencer_monitor (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .invasive_debug_allow(invasive_debug_allow),
    .noninvasive_debug_allow(noninvasive_debug_allow),
    .secure_invasive_debug_allow(secure_invasive_debug_allow),
    .secure_noninvasive_debug_allow(secure_noninvasive_debug_allow),
    .general_outputs(general_outputs),
    .cross_trigger_outputs(cross_trigger_outputs),
    .clock_halt_request(clock_halt_request),
    .trace_enable(trace_enable), .trace_state(trace_state)
);

// ==== tss_probe_model.sv ====
// Stand-in for the monitored debug signals and trigger inputs
`include "tss_defs.vh"
module tss_probe_model (
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    input  wire logic                  evt_go,
    input  wire logic [`TSS_GRP_W-1:0] evt_probe,
    input  wire logic [`TSS_EXT_W-1:0] evt_ext,
    output logic      [`TSS_GRP_W-1:0] probe_signal_group,
    output logic      [`TSS_EXT_W-1:0] ext_trigger_in,
    output logic                       addr_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] bg_r;
    // Moving background, so a stale event value never lingers
    always_ff @(posedge core_clk) begin
        if (srst)
            bg_r <= 32'h0000_0000;
        else
            bg_r <= bg_r + 32'h0000_0001;
    end
    assign probe_signal_group = evt_go ? evt_probe : {bg_r, 32'hFFFF_FFFF};
    assign ext_trigger_in     = evt_go ? evt_ext : ~bg_r[7:0];
    assign addr_request       = evt_go;
endmodule

// ==== tss_sequencer_tb.sv ====
// Register-driven bench for the trigger state sequencer
`include "tss_defs.vh"
module tss_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        evt_go = 1'b0;
    logic [7:0]  evt_ext = 8'h00;
    logic        inv_ok = 1'b1;
    logic        sni_ok = 1'b1;
    logic [31:0] reg_rdata, d;
    logic [63:0] probe;
    logic [7:0]  ext;
    logic        addr_req, halt_o, te_o;
    logic [3:0]  gen_o;
    logic [1:0]  xtr_o;
    logic [2:0]  st_o;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          t1;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    tss_probe_model i_tss_probe_model (
        .core_clk(core_clk), .srst(srst), .evt_go(evt_go),
        .evt_probe(64'h0000_0000_0000_1234), .evt_ext(evt_ext),
        .probe_signal_group(probe), .ext_trigger_in(ext),
        .addr_request(addr_req));
    tss_sequencer i_tss_sequencer (
        .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .probe_signal_group(probe),
        .ext_trigger_in(ext), .addr_request(addr_req),
        .invasive_debug_allow(1'b1), .noninvasive_debug_allow(1'b1),
        .secure_invasive_debug_allow(inv_ok),
        .secure_noninvasive_debug_allow(sni_ok),
        .general_outputs(gen_o), .cross_trigger_outputs(xtr_o),
        .clock_halt_request(halt_o), .trace_enable(te_o),
        .trace_state(st_o));
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    function automatic logic [11:0] sa(input int s, input int f);
        return 12'h100 + 12'(s * 64 + f * 4);
    endfunction
    // Upper probe half stays fully masked with a zero compare value
    task automatic setm(input int s);
        wr(sa(s, 6), 32'h0000_000F);
        wr(sa(s, 7), 32'h0000_0005);
        wr(sa(s, 8), 32'hFFFF_FFFF);
        wr(sa(s, 10), 32'h0000_1234);
    endtask
    task automatic prog(input int s, input logic [31:0] c, n, a, an, aa, t);
        wr(sa(s, 1), c);
        wr(sa(s, 0), n);
        wr(sa(s, 2), a);
        wr(sa(s, 3), an);
        wr(sa(s, 4), aa);
        wr(sa(s, 5), t);
    endtask
    function automatic logic [31:0] outs();
        return {21'h0, st_o, te_o, gen_o, halt_o, xtr_o};
    endfunction
    function automatic logic [31:0] eo(input logic [2:0] s, input logic t,
                                       input logic [7:0] a);
        return {21'h0, s, t, a[7:4], a[2], a[1:0]};
    endfunction
    task automatic wait_st(input logic [2:0] s);
        int c;
        c = 0;
        #1;
        while (st_o !== s && c < 20) begin
            @(posedge core_clk);
            #1 c++;
        end
        chk("trace_state", {29'h0, s}, {29'h0, st_o});
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge core_clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        rd(`TSS_OFF_CFGID, d);
        chk("cfg_cond", 32'h0000_0001, {28'h0, d[19:16]});
        rd(`TSS_OFF_CFGID2, d);
        chk("cfg_tag_w", 32'h0000_000A, {27'h0, d[24:20]});
        rd(12'h0F0, d);
        chk("unmapped", 32'h0000_0000, d);
        wr(`TSS_OFF_PTACT, 8'h31);
        setm(0);
        setm(1);
        prog(0, 8'h40, 8'h01, 8'hA5, 8'h00, 8'h00, 8'h00);
        prog(1, 8'h21, 8'h07, 8'h58, 8'h00, 8'h00, 8'h05);
        wr(`TSS_OFF_CTRL, 8'h01);
        @(posedge core_clk);
        #1 chk("pretrigger", eo(0, 0, 8'h31), outs());
        @(posedge core_clk);
        evt_go  <= 1'b1;
        evt_ext <= 8'h0A;
        repeat (3) @(posedge core_clk);
        #1 chk("half match", eo(0, 0, 8'h31), outs());
        @(posedge core_clk);
        evt_ext <= 8'h15;
        @(posedge core_clk);
        evt_go <= 1'b0;
        wait_st(1);
        t1 = cyc;
        chk("primary fire", eo(1, 1, 8'hA5), outs());
        @(posedge core_clk);
        inv_ok <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk("halt gated", 32'h0, {31'h0, halt_o});
        wait_st(7);
        chk("count span", 32'h0000_0006, cyc - t1);
        chk("final", eo(7, 0, 8'h58), outs());
        rd(`TSS_OFF_TAG, d);
        chk("txn tag", 32'h0000_0234, d);
        @(posedge core_clk);
        sni_ok <= 1'b0;
        inv_ok <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 chk("gated", 32'h0, outs() & 32'h0000_00FF);
        @(posedge core_clk);
        sni_ok <= 1'b1;
        rd(`TSS_OFF_CTRL, d);
        chk("run cleared", 32'h0, {31'h0, d[0]});
        setm(2);
        prog(0, 8'h02, 8'h01, 8'h10, 8'h02, 8'h20, 8'h03);
        prog(2, 8'h00, 8'h04, 8'h40, 8'h03, 8'h80, 8'h00);
        prog(4, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00);
        wr(`TSS_OFF_CTRL, 8'h01);
        wait_st(2);
        chk("alt count", eo(2, 0, 8'h20), outs());
        @(posedge core_clk);
        evt_go <= 1'b1;
        @(posedge core_clk);
        #1 chk("both match", eo(2, 0, 8'h40), outs());
        wait_st(4);
        wait_st(0);
        wr(`TSS_OFF_CTRL, 8'h00);
        give_verdict();
    end
endmodule
